// ---- mwic_motion_wake_irq.v ----
`timescale 1ns/1ns
`include "mwic_regs.vh"
module mwic_motion_wake_irq (
	input wire clk_sys,
	input wire reset_n,
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire buffer_full_event,
	input wire watermark_event,
	input wire aux_two_ready_event,
	input wire aux_one_ready_event,
	input wire accel_ready_event,
	input wire gyro_ready_event,
	input wire accel_data_read,
	input wire gyro_data_read,
	input wire motion_sample_valid,
	input wire [5:0] motion_axis_over,
	input wire auto_sleep_event,
	output wire accel_run,
	output wire [7:0] motion_threshold_out,
	output wire [2:0] motion_sample_rate_out,
	output wire sleeping,
	output wire irq_pin_one,
	output wire irq_pin_two
);
	reg [7:0] sensor_standby;
	reg [7:0] irq_pin_control;
	reg [7:0] pin_one_routing;
	reg [7:0] pin_two_routing;
	reg [7:0] irq_enable_mask_one;
	reg [7:0] wake_sleep_control_one;
	reg [7:0] motion_threshold;
	reg [7:0] motion_duration_count;
	reg [7:0] pin_one_source_primary;
	reg [7:0] pin_two_source_primary;
	reg [7:0] motion_axis_source;
	reg [7:0] pin_two_axis_source;
	reg asleep;
	reg [7:0] next_src_one;
	reg [7:0] next_src_two;
	wire wake_event;
	wire [5:0] wake_axes;
	wire [7:0] raw_events;
	wire [7:0] events;
	wire [7:0] trig_one;
	wire [7:0] trig_two;
	wire rd_rel_one = reg_read && reg_addr == `MWIC_ADDR_PIN1_REL;
	wire rd_rel_two = reg_read && reg_addr == `MWIC_ADDR_PIN2_REL;
	wire [7:0] ready_clear;
	wire motion_en = wake_sleep_control_one[`MWIC_BIT_MOTION_EN];

	// Host write ordering is the host's duty; the block accepts any order
	assign accel_run = ~sensor_standby[`MWIC_BIT_ACCEL_SLEEP];
	assign motion_threshold_out = motion_threshold;
	assign motion_sample_rate_out = wake_sleep_control_one[2:0];
	assign sleeping = asleep;

	mwic_motion_detect u_detect (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.active(accel_run && motion_en && asleep),
		.sample_valid(motion_sample_valid),
		.axis_over(motion_axis_over),
		.duration_value(motion_duration_count),
		.wake_event(wake_event),
		.wake_axes(wake_axes)
	);

	// Bit order: full, watermark, wake, sleep, aux2, aux1, accel, gyro
	assign raw_events = {buffer_full_event, watermark_event, wake_event,
		auto_sleep_event && wake_sleep_control_one[`MWIC_BIT_AUTO_SLEEP] && !asleep,
		aux_two_ready_event, aux_one_ready_event, accel_ready_event, gyro_ready_event};
	assign events = raw_events & irq_enable_mask_one;
	assign trig_one = events & pin_one_routing;
	assign trig_two = events & pin_two_routing;
	// Data read clears data-ready flags besides the release read
	assign ready_clear = {6'h00, accel_data_read, gyro_data_read};

	always @* begin
		next_src_one = pin_one_source_primary & ~ready_clear;
		next_src_two = pin_two_source_primary & ~ready_clear;
		if (rd_rel_one)
			next_src_one = `MWIC_RST_ZERO;
		if (rd_rel_two)
			next_src_two = `MWIC_RST_ZERO;
		// New events win over a clear in the same cycle
		next_src_one = next_src_one | trig_one;
		next_src_two = next_src_two | trig_two;
	end

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			sensor_standby <= `MWIC_RST_STANDBY;
			irq_pin_control <= `MWIC_RST_ZERO;
			pin_one_routing <= `MWIC_RST_PIN1_ROUTE;
			pin_two_routing <= `MWIC_RST_PIN2_ROUTE;
			irq_enable_mask_one <= `MWIC_RST_ZERO;
			wake_sleep_control_one <= `MWIC_RST_ZERO;
			motion_threshold <= `MWIC_RST_ZERO;
			motion_duration_count <= `MWIC_RST_ZERO;
			pin_one_source_primary <= `MWIC_RST_ZERO;
			pin_two_source_primary <= `MWIC_RST_ZERO;
			motion_axis_source <= `MWIC_RST_ZERO;
			pin_two_axis_source <= `MWIC_RST_ZERO;
			asleep <= 1'b0;
		end else begin
			pin_one_source_primary <= next_src_one;
			pin_two_source_primary <= next_src_two;
			if (rd_rel_one)
				motion_axis_source <= `MWIC_RST_ZERO;
			if (rd_rel_two)
				pin_two_axis_source <= `MWIC_RST_ZERO;
			if (trig_one[`MWIC_SRC_MOTION])
				motion_axis_source <= {2'b00, wake_axes};
			if (trig_two[`MWIC_SRC_MOTION])
				pin_two_axis_source <= {2'b00, wake_axes};
			// Wake leaves sleep; only manual sleep or auto sleep re-arms
			if (wake_event)
				asleep <= 1'b0;
			else if (raw_events[`MWIC_SRC_SLEEP])
				asleep <= 1'b1;
			if (reg_write) begin
				case (reg_addr)
					`MWIC_ADDR_STANDBY: sensor_standby <= reg_wdata;
					`MWIC_ADDR_PIN_CTL: irq_pin_control <= reg_wdata;
					`MWIC_ADDR_PIN1_ROUTE: pin_one_routing <= reg_wdata;
					`MWIC_ADDR_PIN2_ROUTE: pin_two_routing <= reg_wdata;
					`MWIC_ADDR_MASK1: irq_enable_mask_one <= reg_wdata;
					`MWIC_ADDR_WAKE_CTL1: begin
						wake_sleep_control_one <= reg_wdata;
						if (reg_wdata[`MWIC_BIT_MAN_SLEEP] && !wake_event)
							asleep <= 1'b1;
					end
					`MWIC_ADDR_THRESHOLD: motion_threshold <= reg_wdata;
					`MWIC_ADDR_DURATION: motion_duration_count <= reg_wdata;
					default: ;
				endcase
			end
		end
	end

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			reg_rdata <= `MWIC_RST_ZERO;
		end else if (reg_read) begin
			case (reg_addr)
				`MWIC_ADDR_PIN1_SRC: reg_rdata <= pin_one_source_primary;
				`MWIC_ADDR_MOTION_AXIS: reg_rdata <= motion_axis_source;
				`MWIC_ADDR_PIN2_SRC: reg_rdata <= pin_two_source_primary;
				`MWIC_ADDR_PIN2_AXIS: reg_rdata <= pin_two_axis_source;
				`MWIC_ADDR_STANDBY: reg_rdata <= sensor_standby;
				`MWIC_ADDR_PIN_CTL: reg_rdata <= irq_pin_control;
				`MWIC_ADDR_PIN1_ROUTE: reg_rdata <= pin_one_routing;
				`MWIC_ADDR_PIN2_ROUTE: reg_rdata <= pin_two_routing;
				`MWIC_ADDR_MASK1: reg_rdata <= irq_enable_mask_one;
				`MWIC_ADDR_WAKE_CTL1: reg_rdata <= {wake_sleep_control_one[7:6], asleep,
					wake_sleep_control_one[4:0]};
				`MWIC_ADDR_THRESHOLD: reg_rdata <= motion_threshold;
				`MWIC_ADDR_DURATION: reg_rdata <= motion_duration_count;
				default: reg_rdata <= `MWIC_RST_ZERO; // Release regs read as zero
			endcase
		end
	end

	mwic_pin_driver u_pin_one (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.enable(irq_pin_control[`MWIC_BIT_PIN1_EN]),
		.polarity(irq_pin_control[`MWIC_BIT_PIN1_POL]),
		.mode(irq_pin_control[1:0]),
		.trigger(|trig_one),
		.condition(|trig_one),
		.latched(|pin_one_source_primary),
		.pin_level(irq_pin_one)
	);

	mwic_pin_driver u_pin_two (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.enable(irq_pin_control[`MWIC_BIT_PIN2_EN]),
		.polarity(irq_pin_control[`MWIC_BIT_PIN2_POL]),
		.mode(irq_pin_control[5:4]),
		.trigger(|trig_two),
		.condition(|trig_two),
		.latched(|pin_two_source_primary),
		.pin_level(irq_pin_two)
	);
	// Serial clock limits lie with the host's bus front end
endmodule // mwic_motion_wake_irq

// ---- mwic_regs.vh ----
`ifndef MWIC_REGS_VH
`define MWIC_REGS_VH
`define MWIC_ADDR_MOTION_AXIS 8'h38
`define MWIC_ADDR_PIN1_SRC 8'h37
`define MWIC_ADDR_PIN1_REL 8'h39
`define MWIC_ADDR_PIN2_SRC 8'h3B
`define MWIC_ADDR_PIN2_AXIS 8'h3C
`define MWIC_ADDR_PIN2_REL 8'h3D
`define MWIC_ADDR_STANDBY 8'h43
`define MWIC_ADDR_PIN_CTL 8'h45
`define MWIC_ADDR_PIN1_ROUTE 8'h46
`define MWIC_ADDR_PIN2_ROUTE 8'h47
`define MWIC_ADDR_MASK1 8'h48
`define MWIC_ADDR_WAKE_CTL1 8'h4B
`define MWIC_ADDR_THRESHOLD 8'h4D
`define MWIC_ADDR_DURATION 8'h4E
`define MWIC_RST_STANDBY 8'hEF
`define MWIC_RST_PIN1_ROUTE 8'hFF
`define MWIC_RST_PIN2_ROUTE 8'h00
`define MWIC_RST_ZERO 8'h00
`define MWIC_BIT_ACCEL_SLEEP 0
`define MWIC_BIT_PIN1_EN 3
`define MWIC_BIT_PIN1_POL 2
`define MWIC_BIT_PIN2_EN 7
`define MWIC_BIT_PIN2_POL 6
`define MWIC_BIT_AUTO_SLEEP 7
`define MWIC_BIT_MOTION_EN 6
`define MWIC_BIT_MAN_SLEEP 5
`define MWIC_SRC_MOTION 5
`define MWIC_SRC_SLEEP 4
`define MWIC_SRC_ACC_RDY 1
`define MWIC_SRC_GYRO_RDY 0
`define MWIC_MODE_LATCH 2'h0
`define MWIC_MODE_SHORT 2'h1
`define MWIC_MODE_LONG 2'h2
`define MWIC_MODE_LIVE 2'h3
`define MWIC_CLK_MHZ 25
`define MWIC_SHORT_PULSE_US 50
`define MWIC_LONG_PULSE_US 200
`define MWIC_SHORT_CYCLES (`MWIC_SHORT_PULSE_US * `MWIC_CLK_MHZ)
`define MWIC_LONG_CYCLES (`MWIC_LONG_PULSE_US * `MWIC_CLK_MHZ)
`define MWIC_PULSE_CNT_W 13
`endif

// ---- mwic_pin_driver.v ----
`timescale 1ns/1ns
`include "mwic_regs.vh"
module mwic_pin_driver (
	input wire clk_sys,
	input wire reset_n,
	input wire enable,
	input wire polarity,
	input wire [1:0] mode,
	input wire trigger,
	input wire condition,
	input wire latched,
	output reg pin_level
);
	reg [`MWIC_PULSE_CNT_W-1:0] pulse_cnt;
	reg [`MWIC_PULSE_CNT_W-1:0] next_pulse_cnt;
	reg asserted;
	localparam integer SHORT_FULL = `MWIC_SHORT_CYCLES;
	localparam integer LONG_FULL = `MWIC_LONG_CYCLES;
	// Counter sized for the long pulse, so the cut drops only zero bits
	localparam [`MWIC_PULSE_CNT_W-1:0] SHORT_LEN = SHORT_FULL[`MWIC_PULSE_CNT_W-1:0];
	localparam [`MWIC_PULSE_CNT_W-1:0] LONG_LEN = LONG_FULL[`MWIC_PULSE_CNT_W-1:0];
	always @* begin
		next_pulse_cnt = pulse_cnt;
		if (pulse_cnt != {`MWIC_PULSE_CNT_W{1'b0}})
			next_pulse_cnt = pulse_cnt - 1'b1; // Retrigger ignored mid-pulse
		else if (trigger && mode == `MWIC_MODE_SHORT)
			next_pulse_cnt = SHORT_LEN;
		else if (trigger && mode == `MWIC_MODE_LONG)
			next_pulse_cnt = LONG_LEN;
		case (mode)
			`MWIC_MODE_LATCH: asserted = latched;
			`MWIC_MODE_LIVE: asserted = condition;
			default: asserted = pulse_cnt != {`MWIC_PULSE_CNT_W{1'b0}};
		endcase
	end
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			pulse_cnt <= {`MWIC_PULSE_CNT_W{1'b0}};
			pin_level <= 1'b1;
		end else begin
			pulse_cnt <= next_pulse_cnt;
			// Idle level is the inverse of polarity, also when disabled
			pin_level <= (enable & asserted) ~^ polarity;
		end
	end
endmodule // mwic_pin_driver

// ---- mwic_motion_detect.v ----
`timescale 1ns/1ns
`include "mwic_regs.vh"
module mwic_motion_detect (
	input wire clk_sys,
	input wire reset_n,
	input wire active,
	input wire sample_valid,
	input wire [5:0] axis_over,
	input wire [7:0] duration_value,
	output reg wake_event,
	output reg [5:0] wake_axes
);
	reg [7:0] run_cnt;
	wire over = |axis_over;
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			run_cnt <= `MWIC_RST_ZERO;
			wake_event <= 1'b0;
			wake_axes <= 6'h00;
		end else begin
			wake_event <= 1'b0;
			if (!active || (sample_valid && !over)) begin
				run_cnt <= `MWIC_RST_ZERO; // Any sample below threshold restarts
			end else if (sample_valid) begin
				if (run_cnt >= duration_value) begin
					wake_event <= 1'b1;
					wake_axes <= axis_over;
					run_cnt <= `MWIC_RST_ZERO;
				end else begin
					run_cnt <= run_cnt + 8'h01;
				end
			end
		end
	end
endmodule // mwic_motion_detect

// ---- mwic_monitor.sv ----
`timescale 1ns/1ns
module mwic_monitor (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic accel_run,
	input wire logic sleeping,
	input wire logic irq_pin_one,
	input wire logic irq_pin_two,
	input wire logic auto_sleep_event
);
	logic [7:0] ctl;
	logic [12:0] cnt;
	wire rel1 = reg_read && reg_addr == 8'h39;
	always @(posedge clk_sys) begin
		if (!reset_n)
			ctl <= 8'h00;
		else if (reg_write && reg_addr == 8'h45)
			ctl <= reg_wdata;
		cnt <= (reset_n && irq_pin_one) ? cnt + 13'h0001 : 13'h0000;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	accel_run_a:
		assert property (reg_write && reg_addr == 8'h43 |=> accel_run == !$past(reg_wdata[0]))
		else $error("accel run does not follow standby bit");
	release_zero_a:
		assert property (reg_read && reg_addr == 8'h3D |=> reg_rdata == 8'h00)
		else $error("release read returned data");
	pin_one_off_a:
		assert property (!ctl[3] |=> irq_pin_one == !$past(ctl[2]))
		else $error("disabled pin one left idle");
	pin_two_off_a:
		assert property (!ctl[7] |=> irq_pin_two == !$past(ctl[6]))
		else $error("disabled pin two left idle");
	latch_hold_a:
		assert property (ctl[3:0] == 4'hC && $stable(ctl) && irq_pin_one && !reg_write && !rel1 && !$past(rel1)
			|=> irq_pin_one)
		else $error("latched pin dropped without release");
	release_drop_a:
		assert property (ctl[3:0] == 4'hC && rel1 && !reg_write |=> ##1 !irq_pin_one)
		else $error("latched pin held after release");
	// Idle level moves with polarity, so a settled control byte is required
	pulse_width_a:
		assert property ($fell(irq_pin_one) && ctl[3:2] == 2'h3 && ^ctl[1:0] && $past(ctl, 2) == ctl
			|-> cnt == (ctl[1] ? 13'h1388 : 13'h04E2))
		else $error("pulse width wrong");
	sleep_force_a:
		assert property (reg_write && reg_addr == 8'h4B && reg_wdata[5] |=> sleeping)
		else $error("manual sleep not entered");
	stay_awake_a:
		assert property (!sleeping && !(reg_write && reg_addr == 8'h4B) && !auto_sleep_event |=> !sleeping)
		else $error("left wake mode unprompted");
endmodule // mwic_monitor
bind mwic_motion_wake_irq mwic_monitor mon (.clk_sys(clk_sys), .reset_n(reset_n), .reg_write(reg_write),
	.reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.accel_run(accel_run), .sleeping(sleeping), .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two),
	.auto_sleep_event(auto_sleep_event));

// ---- mwic_host_model.sv ----
`timescale 1ns/1ns
module mwic_host_model (
	input wire logic clk_sys,
	input wire logic [7:0] reg_rdata,
	output logic reg_write,
	output logic reg_read,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	logic [7:0] junk;
	// A one-cycle strobe at most every other cycle stands in for the serial link and its rate limits
	initial begin
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_write = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_write = 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_read = 1'b1;
		reg_addr = a;
		@(negedge clk_sys);
		reg_read = 1'b0;
		d = reg_rdata;
	endtask
	// All sensors parked and both pins released before reconfiguring
	task park;
		wr(8'h43, 8'hEF);
		rd(8'h39, junk);
		rd(8'h3D, junk);
	endtask
endmodule // mwic_host_model

// ---- motion_wake_interrupt_ctrl_bench.sv ----
`timescale 1ns/1ns
module motion_wake_interrupt_ctrl_bench;
	localparam logic [63:0] RA = 64'h43_46_47_48_45_4B_4D_4E;
	localparam logic [63:0] RV = 64'hEF_FF_00_00_00_00_00_00;
	logic clk_sys, reset_n, smv;
	logic [7:0] ev, v;
	logic [1:0] dr;
	logic [5:0] ax;
	logic [15:0] n;
	wire reg_write, reg_read, accel_run, sleeping, irq_pin_one, irq_pin_two;
	wire [7:0] reg_addr, reg_wdata, reg_rdata, motion_threshold_out;
	wire [2:0] motion_sample_rate_out;
	int err_total, tests_run, cyc;
	mwic_host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	mwic_motion_wake_irq dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_write(reg_write), .reg_read(reg_read),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .buffer_full_event(ev[7]),
		.watermark_event(ev[6]), .aux_two_ready_event(ev[3]), .aux_one_ready_event(ev[2]),
		.accel_ready_event(ev[1]), .gyro_ready_event(ev[0]), .accel_data_read(dr[1]), .gyro_data_read(dr[0]),
		.motion_sample_valid(smv), .motion_axis_over(ax), .auto_sleep_event(ev[4]), .accel_run(accel_run),
		.motion_threshold_out(motion_threshold_out), .motion_sample_rate_out(motion_sample_rate_out),
		.sleeping(sleeping), .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two));
	task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task final_report;
		if (err_total == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		host.rd(a, v);
		chk(nm, {8'h00, v}, {8'h00, e});
	endtask
	// Trailing edge lets the pin update land before the caller looks
	task pulse(input logic [7:0] m);
		@(negedge clk_sys);
		ev = m;
		@(negedge clk_sys);
		ev = 8'h00;
		@(negedge clk_sys);
	endtask
	task smp(input logic [5:0] a);
		@(negedge clk_sys);
		smv = 1'b1;
		ax = a;
		@(negedge clk_sys);
		smv = 1'b0;
	endtask
	task cfg(input logic [7:0] c, input logic [7:0] m, input logic [7:0] r);
		host.wr(8'h45, c);
		host.wr(8'h48, m);
		host.wr(8'h46, r);
	endtask
	task rel1;
		host.rd(8'h39, v);
		@(negedge clk_sys);
	endtask
	task t_defaults;
		for (int i = 0; i < 8; i++)
			rchk("reset value", RA[63 - 8 * i -: 8], RV[63 - 8 * i -: 8]);
		chk("idle pins", {14'h0000, irq_pin_one, irq_pin_two}, 16'h0003);
	endtask
	task t_latch;
		for (int i = 0; i < 8; i++) begin
			if (i == 4 || i == 5)
				continue;
			cfg(8'h0C, 8'h01 << i, 8'h01 << i);
			pulse(8'h01 << i);
			chk("latched pin", {15'h0000, irq_pin_one}, 16'h0001);
			rchk("source set", 8'h37, 8'h01 << i);
			chk("still latched", {15'h0000, irq_pin_one}, 16'h0001);
			rel1;
			chk("released pin", {15'h0000, irq_pin_one}, 16'h0000);
			rchk("source cleared", 8'h37, 8'h00);
		end
	endtask
	task t_route;
		cfg(8'hCC, 8'h00, 8'h80);
		host.wr(8'h47, 8'h80);
		pulse(8'h80);
		chk("masked", {14'h0000, irq_pin_one, irq_pin_two}, 16'h0000);
		host.wr(8'h48, 8'h80);
		pulse(8'h80);
		chk("both pins", {14'h0000, irq_pin_one, irq_pin_two}, 16'h0003);
		host.rd(8'h3D, v);
		@(negedge clk_sys);
		chk("pin two released", {14'h0000, irq_pin_one, irq_pin_two}, 16'h0002);
		rel1;
		cfg(8'h08, 8'h80, 8'h80);
		pulse(8'h80);
		chk("active low", {14'h0000, irq_pin_one, irq_pin_two}, 16'h0001);
		rel1;
		chk("idle high", {15'h0000, irq_pin_one}, 16'h0001);
	endtask
	// Pin disabled here: a flag cleared by a data read may drop a latched pin
	task t_drdy;
		cfg(8'h00, 8'h03, 8'h03);
		for (int k = 0; k < 2; k++) begin
			pulse(8'h01 << k);
			rchk("ready flag set", 8'h37, 8'h01 << k);
			dr = 2'h1 << k;
			@(negedge clk_sys);
			dr = 2'h0;
			rchk("ready flag cleared", 8'h37, 8'h00);
			rel1;
		end
	endtask
	task t_pulse;
		for (logic [7:0] m = 8'h0D; m < 8'h0F; m++) begin
			cfg(m, 8'h80, 8'h80);
			pulse(8'h80);
			n = 16'h0000;
			while (irq_pin_one === 1'b1 && n < 16'h1770) begin
				n++;
				@(negedge clk_sys);
				ev = (n == 16'h0064) ? 8'h80 : 8'h00;
			end
			chk("pulse length", n, m == 8'h0D ? 16'h04E2 : 16'h1388);
			rel1;
		end
		cfg(8'h0F, 8'h80, 8'h80);
		// Live mode registers the routed event itself, a cycle ahead of latched mode
		@(negedge clk_sys);
		ev = 8'h80;
		@(negedge clk_sys);
		ev = 8'h00;
		chk("live high", {15'h0000, irq_pin_one}, 16'h0001);
		@(negedge clk_sys);
		chk("live low", {15'h0000, irq_pin_one}, 16'h0000);
		rel1;
	endtask
	task t_motion;
		host.park;
		cfg(8'h0C, 8'h20, 8'h20);
		host.wr(8'h4B, 8'h66);
		host.wr(8'h4D, 8'h08);
		host.wr(8'h4E, 8'h01);
		host.wr(8'h43, 8'hEE);
		chk("run rate level", {3'h0, accel_run, sleeping, motion_sample_rate_out, motion_threshold_out},
			16'h1E08);
		rchk("duration", 8'h4E, 8'h01);
		smp(6'h21);
		smp(6'h00);
		smp(6'h21);
		repeat (2) @(negedge clk_sys);
		chk("broken motion", {14'h0000, sleeping, irq_pin_one}, 16'h0002);
		smp(6'h21);
		n = 16'h0000;
		while (irq_pin_one !== 1'b1 && n < 16'h0008) begin
			n++;
			@(negedge clk_sys);
		end
		chk("woken", {14'h0000, sleeping, irq_pin_one}, 16'h0001);
		rchk("motion flag", 8'h37, 8'h20);
		rchk("axes", 8'h38, 8'h21);
		smp(6'h21);
		smp(6'h21);
		chk("stays awake", {15'h0000, sleeping}, 16'h0000);
		host.wr(8'h4B, 8'hC6);
		pulse(8'h10);
		chk("auto sleep", {15'h0000, sleeping}, 16'h0001);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		reset_n = 1'b0;
		ev = 8'h00;
		dr = 2'h0;
		smv = 1'b0;
		ax = 6'h00;
		repeat (6) @(negedge clk_sys);
		reset_n = 1'b1;
		t_defaults;
		host.park;
		t_latch;
		t_route;
		t_drdy;
		t_pulse;
		t_motion;
		final_report;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			final_report;
		end
	end
endmodule // motion_wake_interrupt_ctrl_bench
